// ===== verilog/rx_dma_pkg.sv
package rx_dma_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int GAP_UNIT_NS   = 8000;
  localparam int GAP_UNIT_CYC  = (GAP_UNIT_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // register index map (mapped_register_space)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_SEG    = 4'h1;
  localparam logic [3:0] REG_BASE   = 4'h2;
  localparam logic [3:0] REG_BOUND  = 4'h3;
  localparam logic [3:0] REG_PTR    = 4'h4;
  localparam logic [3:0] REG_BCNT   = 4'h5;
  localparam logic [3:0] REG_FCSR   = 4'h6;
  localparam logic [3:0] REG_GAP    = 4'h7;
  localparam logic [3:0] REG_GLOB   = 4'h8;
  localparam logic [3:0] REG_MATCH0 = 4'h9;
  localparam logic [3:0] REG_BCUR   = 4'hD;
  localparam int         MATCH_NUM  = 4;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT  = 2;
  localparam int CTRL_CIRC_BIT = 3;
  localparam int CTRL_IE_BIT   = 4;
  localparam int CTRL_TOIE_BIT = 5;
  localparam int FCSR_FLUSH_BIT = 0;
  localparam int PKT_CNT_W     = 14;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  typedef enum logic [1:0] {
    MODE_CHAIN, MODE_PERIODIC, MODE_TIMEOUT, MODE_MATCH
  } mode_t;

  typedef enum logic [1:0] {HDR_IDLE, HDR_LOW, HDR_HIGH} hdr_state_t;

endpackage

// ===== verilog/rx_byte_fifo.sv
`timescale 1ns/1ns
module rx_byte_fifo (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       flush_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  output logic            full_o,
  output logic            empty_o,
  output logic      [2:0] level_o,
  output logic      [1:0] head_o
);
  // four bytes; read data appear one cycle after rd_i
  logic [7:0] mem_reg [4];
  logic [2:0] wr_ptr_reg;
  logic [2:0] rd_ptr_reg;
  logic [7:0] rd_data_reg;

  assign level_o   = wr_ptr_reg - rd_ptr_reg;
  assign full_o    = (level_o == 3'h4);
  assign empty_o   = (level_o == 3'h0);
  assign head_o    = rd_ptr_reg[1:0];
  assign rd_data_o = rd_data_reg;

  always_ff @(posedge clk_i) begin
    if (wr_i & ~full_o) mem_reg[wr_ptr_reg[1:0]] <= wr_data_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg  <= 3'h0;
      rd_ptr_reg  <= 3'h0;
      rd_data_reg <= 8'h00;
    end else if (flush_i) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
    end else begin
      if (wr_i & ~full_o) wr_ptr_reg <= wr_ptr_reg + 3'h1;
      if (rd_i & ~empty_o) begin
        rd_ptr_reg  <= rd_ptr_reg + 3'h1;
        rd_data_reg <= mem_reg[rd_ptr_reg[1:0]];
      end
    end
  end
endmodule

// ===== verilog/two_entry_buffer.sv
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  logic [WIDTH-1:0] slot0_reg;
  logic [WIDTH-1:0] slot1_reg;
  logic [1:0]       cnt_reg;
  wire logic        push = in_valid_i & in_ready_o;
  wire logic        pop  = out_valid_o & out_ready_i;
  wire logic [1:0]  wr_idx = cnt_reg - {1'b0, pop};

  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = slot0_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot0_reg <= '0;
      slot1_reg <= '0;
      cnt_reg   <= 2'h0;
    end else begin
      if (pop) slot0_reg <= slot1_reg;
      if (push && wr_idx == 2'h0) slot0_reg <= in_data_i;
      if (push && wr_idx == 2'h1) slot1_reg <= in_data_i;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== verilog/rx_dma_channel.sv
`timescale 1ns/1ns
module rx_dma_channel
  import rx_dma_pkg::*;
#(
  parameter logic [2:0] CHAN_IDX = 3'h0
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        autobaud_start_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  input  wire logic        pkt_end_i,
  input  wire logic        pkt_abort_i,
  input  wire logic        pkt_crc_err_i,
  output logic             mem_valid_o,
  output logic      [23:0] mem_addr_o,
  output logic      [7:0]  mem_data_o,
  input  wire logic        mem_ready_i,
  output logic             irq_o
);

  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    return a == idx;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]       ctrl_reg;
  logic [7:0]       seg_reg;
  logic [7:0]       base_reg;
  logic [7:0]       bound_reg;
  logic [15:0]      ptr_reg;
  logic [15:0]      bcnt_reg;
  logic [15:0]      bcur_reg;
  logic [7:0]       gap_preset_reg;
  logic [7:0]       gap_cnt_reg;
  logic             gap_armed_reg;
  logic [9:0]       unit_cnt_reg;
  logic [15:0]      glob_reg;
  logic [7:0]       match_reg [MATCH_NUM];
  logic [15:0]      rdata_reg;
  logic [PKT_CNT_W-1:0] pkt_cnt_reg;
  logic [1:0]       pkt_stat_reg;
  logic             pkt_pend_reg;
  hdr_state_t       hdr_state_reg;
  logic             stage_valid_reg;
  logic             irq_reg;

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  wire logic wr_ctrl  = reg_wr_i & hit(reg_addr_i, REG_CTRL);
  wire logic wr_seg   = reg_wr_i & hit(reg_addr_i, REG_SEG);
  wire logic wr_base  = reg_wr_i & hit(reg_addr_i, REG_BASE);
  wire logic wr_bound = reg_wr_i & hit(reg_addr_i, REG_BOUND);
  wire logic wr_ptr   = reg_wr_i & hit(reg_addr_i, REG_PTR);
  wire logic wr_bcnt  = reg_wr_i & hit(reg_addr_i, REG_BCNT);
  wire logic wr_fcsr  = reg_wr_i & hit(reg_addr_i, REG_FCSR);
  wire logic wr_gap   = reg_wr_i & hit(reg_addr_i, REG_GAP);
  wire logic wr_glob  = reg_wr_i & hit(reg_addr_i, REG_GLOB);
  wire logic wr_bcur  = reg_wr_i & hit(reg_addr_i, REG_BCUR);

  wire mode_t mode    = mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  wire logic  run     = ctrl_reg[CTRL_RUN_BIT];
  wire logic  circ    = ctrl_reg[CTRL_CIRC_BIT];
  wire logic  flush   = wr_fcsr & reg_wdata_i[FCSR_FLUSH_BIT];

  // ----------------------------------------------------------------------
  // receive side and FIFO
  // ----------------------------------------------------------------------
  logic [7:0] fifo_rdata;
  logic       fifo_full;
  logic       fifo_empty;
  logic [2:0] fifo_level;
  logic [1:0] fifo_head;
  logic       buf_in_ready;

  // new characters are held off while a packet trailer is pending so
  // the next packet cannot overtake it
  assign rx_ready_o = run & ~fifo_full & ~pkt_pend_reg;
  wire logic rx_fire = rx_valid_i & rx_ready_o;

  wire logic hdr_busy  = (hdr_state_reg != HDR_IDLE);
  wire logic data_take = stage_valid_reg & buf_in_ready & ~hdr_busy;
  wire logic hdr_take  = hdr_busy & buf_in_ready;
  wire logic take      = data_take | hdr_take;
  wire logic fifo_rd   = ~fifo_empty & (~stage_valid_reg | data_take);

  rx_byte_fifo u_fifo (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .flush_i   (flush),
    .wr_i      (rx_fire),
    .wr_data_i (rx_data_i),
    .rd_i      (fifo_rd),
    .rd_data_o (fifo_rdata),
    .full_o    (fifo_full),
    .empty_o   (fifo_empty),
    .level_o   (fifo_level),
    .head_o    (fifo_head)
  );

  // ----------------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------------
  wire logic [15:0] ptr_inc  = ptr_reg + 16'h0001;
  wire logic        wrap_hit = circ & (ptr_inc == {bound_reg, 8'h00});
  wire logic [15:0] ptr_adv  = wrap_hit ? {base_reg, 8'h00}
                                        : ptr_inc;
  wire logic [23:0] dma_addr = {seg_reg, ptr_reg};

  wire logic [7:0] hdr_low  = pkt_cnt_reg[7:0];
  wire logic [7:0] hdr_high = {pkt_stat_reg, pkt_cnt_reg[13:8]};
  wire logic [7:0] out_byte = (hdr_state_reg == HDR_LOW)  ? hdr_low  :
                              (hdr_state_reg == HDR_HIGH) ? hdr_high :
                              fifo_rdata;

  two_entry_buffer #(.WIDTH(32)) u_buf (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  ((stage_valid_reg & ~hdr_busy) | hdr_busy),
    .in_data_i   ({dma_addr, out_byte}),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (mem_valid_o),
    .out_data_o  ({mem_addr_o, mem_data_o}),
    .out_ready_i (mem_ready_i)
  );

  // ----------------------------------------------------------------------
  // mode events
  // ----------------------------------------------------------------------
  logic [MATCH_NUM-1:0] match_vec;
  genvar gi;
  generate
    for (gi = 0; gi < MATCH_NUM; gi++) begin : g_match
      wire logic wr_m = reg_wr_i & hit(reg_addr_i, REG_MATCH0 + 4'(gi));
      assign match_vec[gi] = (fifo_rdata == match_reg[gi]);
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) match_reg[gi] <= BYTE_RST;
        else if (wr_m) match_reg[gi] <= reg_wdata_i[7:0];
      end
    end
  endgenerate

  wire logic ev_match = (mode == MODE_MATCH) & data_take
                        & (|match_vec);
  wire logic per_step = (mode == MODE_PERIODIC) & data_take;
  wire logic per_wrap = per_step & (bcur_reg <= 16'h0001);
  wire logic ev_pkt   = (hdr_state_reg == HDR_HIGH) & hdr_take;
  wire logic unit_tick = (unit_cnt_reg == 10'(GAP_UNIT_CYC - 1));
  wire logic gap_on   = run & (mode == MODE_TIMEOUT);
  wire logic ev_gap   = gap_on & gap_armed_reg & unit_tick & ~rx_fire
                        & (gap_cnt_reg <= 8'h01);
  wire logic pkt_take = run & (mode == MODE_CHAIN) & pkt_end_i
                        & ~pkt_pend_reg;

  wire logic [3:0]  ev_idx = {CHAN_IDX, 1'b0};
  wire logic [3:0]  to_idx = {CHAN_IDX, 1'b1};
  wire logic [15:0] set_vec =
    ((ev_pkt | per_wrap | ev_match) ? (16'h0001 << ev_idx) : 16'h0000) |
    (ev_gap ? (16'h0001 << to_idx) : 16'h0000);
  wire logic [15:0] clr_vec = wr_glob ? reg_wdata_i : 16'h0000;

  // ----------------------------------------------------------------------
  // register file and datapath state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= CTRL_RST;
      seg_reg  <= BYTE_RST;
      base_reg <= BYTE_RST;
      bound_reg <= BYTE_RST;
      gap_preset_reg <= BYTE_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata_i[7:0];
      if (autobaud_start_i) ctrl_reg[CTRL_RUN_BIT] <= 1'b1;
      if (wr_seg) seg_reg <= reg_wdata_i[7:0];
      if (wr_base) base_reg <= reg_wdata_i[7:0];
      if (wr_bound) bound_reg <= reg_wdata_i[7:0];
      if (wr_gap) gap_preset_reg <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) ptr_reg <= WORD_RST;
    else if (wr_ptr) ptr_reg <= reg_wdata_i;
    else if (take) ptr_reg <= ptr_adv;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcnt_reg <= WORD_RST;
      bcur_reg <= WORD_RST;
    end else begin
      if (wr_bcnt) bcnt_reg <= reg_wdata_i;
      if (wr_bcnt | wr_bcur) bcur_reg <= reg_wdata_i;
      else if (per_wrap) bcur_reg <= bcnt_reg;
      else if (per_step) bcur_reg <= bcur_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) unit_cnt_reg <= 10'h000;
    else if (unit_tick) unit_cnt_reg <= 10'h000;
    else unit_cnt_reg <= unit_cnt_reg + 10'h001;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_cnt_reg   <= BYTE_RST;
      gap_armed_reg <= 1'b0;
    end else if (!gap_on) begin
      gap_armed_reg <= 1'b0;
    end else if (rx_fire) begin
      gap_cnt_reg   <= gap_preset_reg;
      gap_armed_reg <= 1'b1;
    end else if (ev_gap) begin
      gap_cnt_reg   <= 8'h00;
      gap_armed_reg <= 1'b0;
    end else if (gap_armed_reg & unit_tick) begin
      gap_cnt_reg   <= gap_cnt_reg - 8'h01;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) glob_reg <= WORD_RST;
    else glob_reg <= (glob_reg & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) irq_reg <= 1'b0;
    else irq_reg <= (glob_reg[ev_idx] & ctrl_reg[CTRL_IE_BIT])
                  | (glob_reg[to_idx] & ctrl_reg[CTRL_TOIE_BIT]);
  end
  assign irq_o = irq_reg;

  // ----------------------------------------------------------------------
  // packet trailer sequencer
  // ----------------------------------------------------------------------
  wire logic hdr_go = pkt_pend_reg & ~hdr_busy & fifo_empty
                      & ~stage_valid_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hdr_state_reg <= HDR_IDLE;
      pkt_pend_reg  <= 1'b0;
      pkt_stat_reg  <= 2'h0;
      pkt_cnt_reg   <= '0;
    end else begin
      if (pkt_take) begin
        pkt_pend_reg <= 1'b1;
        pkt_stat_reg <= {pkt_abort_i, pkt_crc_err_i};
      end
      if (data_take & (mode == MODE_CHAIN))
        pkt_cnt_reg <= pkt_cnt_reg + 14'h0001;
      case (hdr_state_reg)
        HDR_IDLE: if (hdr_go) hdr_state_reg <= HDR_LOW;
        HDR_LOW:  if (hdr_take) hdr_state_reg <= HDR_HIGH;
        HDR_HIGH: begin
          if (hdr_take) begin
            hdr_state_reg <= HDR_IDLE;
            pkt_pend_reg  <= 1'b0;
            pkt_cnt_reg   <= '0;
          end
        end
        default: hdr_state_reg <= HDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) stage_valid_reg <= 1'b0;
    else if (flush) stage_valid_reg <= 1'b0;
    else stage_valid_reg <= fifo_rd | (stage_valid_reg & ~data_take);
  end

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  wire logic [15:0] fcsr_view = {9'h000, fifo_level, fifo_head,
                                 fifo_full, fifo_empty};
  wire logic [15:0] rd_mux =
    hit(reg_addr_i, REG_CTRL)  ? {8'h00, ctrl_reg}       :
    hit(reg_addr_i, REG_SEG)   ? {8'h00, seg_reg}        :
    hit(reg_addr_i, REG_BASE)  ? {8'h00, base_reg}       :
    hit(reg_addr_i, REG_BOUND) ? {8'h00, bound_reg}      :
    hit(reg_addr_i, REG_PTR)   ? ptr_reg                 :
    hit(reg_addr_i, REG_BCNT)  ? bcnt_reg                :
    hit(reg_addr_i, REG_FCSR)  ? fcsr_view               :
    hit(reg_addr_i, REG_GAP)   ? {8'h00, gap_preset_reg} :
    hit(reg_addr_i, REG_GLOB)  ? glob_reg                :
    hit(reg_addr_i, REG_BCUR)  ? bcur_reg                :
    (reg_addr_i >= REG_MATCH0 && reg_addr_i < REG_BCUR)
      ? {8'h00, match_reg[2'(reg_addr_i - REG_MATCH0)]} : 16'h0000;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) rdata_reg <= WORD_RST;
    else if (reg_rd_i) rdata_reg <= rd_mux;
  end
  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_trailer_low;
    hdr_state_reg == HDR_LOW && hdr_take;
  endsequence
  sequence s_trailer_high;
    hdr_state_reg == HDR_HIGH && hdr_take;
  endsequence

  property p_trailer_seq;
    @(posedge clk_i) disable iff (!nrst_i)
    s_trailer_low |=> hdr_state_reg == HDR_HIGH;
  endproperty
  a_trailer_seq: assert property (p_trailer_seq)
    else $error("trailer low byte not followed by high byte");

  property p_trailer_flag;
    @(posedge clk_i) disable iff (!nrst_i)
    s_trailer_high |=> glob_reg[ev_idx] && pkt_cnt_reg == 14'h0000
                       && !pkt_pend_reg;
  endproperty
  a_trailer_flag: assert property (p_trailer_flag)
    else $error("packet end did not flag or clear count");

  property p_pkt_count;
    @(posedge clk_i) disable iff (!nrst_i)
    data_take && mode == MODE_CHAIN
      |=> pkt_cnt_reg == $past(pkt_cnt_reg) + 14'h0001;
  endproperty
  a_pkt_count: assert property (p_pkt_count)
    else $error("packet byte count did not advance");

  property p_run_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    run && !wr_ctrl |=> run;
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("channel stopped without processor command");

  property p_period_reload;
    @(posedge clk_i) disable iff (!nrst_i)
    per_wrap && !wr_bcnt && !wr_bcur
      |=> bcur_reg == $past(bcnt_reg) && glob_reg[ev_idx];
  endproperty
  a_period_reload: assert property (p_period_reload)
    else $error("byte counter did not reload with flag");

  property p_gap_fire;
    @(posedge clk_i) disable iff (!nrst_i)
    ev_gap |=> glob_reg[to_idx] && !gap_armed_reg ##1 irq_o
               || !ctrl_reg[CTRL_TOIE_BIT] || wr_glob;
  endproperty
  a_gap_fire: assert property (p_gap_fire)
    else $error("gap timeout did not flag");

  property p_gap_reload;
    @(posedge clk_i) disable iff (!nrst_i)
    rx_fire && gap_on && !wr_gap |=> gap_cnt_reg == $past(gap_preset_reg);
  endproperty
  a_gap_reload: assert property (p_gap_reload)
    else $error("gap countdown not reloaded on character");

  property p_match_flag;
    @(posedge clk_i) disable iff (!nrst_i)
    ev_match |=> glob_reg[ev_idx];
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("stored match character did not flag");

  property p_wrap;
    @(posedge clk_i) disable iff (!nrst_i)
    take && !wr_ptr && wrap_hit |=> ptr_reg == {$past(base_reg), 8'h00};
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap to base");

  property p_autostart;
    @(posedge clk_i) disable iff (!nrst_i)
    autobaud_start_i |=> run;
  endproperty
  a_autostart: assert property (p_autostart)
    else $error("autobaud start did not start channel");

  property p_stopped_gate;
    @(posedge clk_i) disable iff (!nrst_i)
    !run |-> !rx_ready_o;
  endproperty
  a_stopped_gate: assert property (p_stopped_gate)
    else $error("stopped channel accepted a character");

endmodule

// ===== test/mem_sink.sv
`timescale 1ns/1ns
module mem_sink (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        mem_valid_i,
  input  wire logic [23:0] mem_addr_i,
  input  wire logic [7:0]  mem_data_i,
  output logic             mem_ready_o
);
  logic [31:0] got[$];
  logic [7:0]  lfsr;
  // stalls come in runs so the fifo really backs up
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lfsr        <= 8'hA5;
      mem_ready_o <= 1'b0;
    end else begin
      lfsr        <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      mem_ready_o <= lfsr[1] | lfsr[0];
      if (mem_valid_i && mem_ready_o)
        got.push_back({mem_addr_i, mem_data_i});
    end
  end
endmodule

// ===== test/rx_serial_dma_channel_tb_top.sv
`timescale 1ns/1ns
module rx_serial_dma_channel_tb_top;
  import rx_dma_pkg::*;
  logic        clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        autobaud_start_i = 1'b0, rx_valid_i = 1'b0, pkt_end_i = 1'b0;
  logic        pkt_abort_i = 1'b0, pkt_crc_err_i = 1'b0, rx_ready_o, irq_o;
  logic        mem_valid_o, mem_ready_i, circ;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, v, d, p, base, bound;
  logic [7:0]  rx_data_i = 8'h00, mem_data_o, q[6];
  logic [23:0] mem_addr_o;
  logic [31:0] seed = 32'h00015FC0;
  logic [3:0]  ra[5] = '{REG_SEG, REG_GAP, REG_BCNT, REG_PTR, 4'hE};
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  always #4 clk_i = ~clk_i;
  rx_dma_channel uut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .autobaud_start_i(autobaud_start_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
    .pkt_end_i(pkt_end_i), .pkt_abort_i(pkt_abort_i),
    .pkt_crc_err_i(pkt_crc_err_i), .mem_valid_o(mem_valid_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .mem_ready_i(mem_ready_i), .irq_o(irq_o));
  mem_sink mem (.clk_i(clk_i), .nrst_i(nrst_i), .mem_valid_i(mem_valid_o),
    .mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o),
    .mem_ready_o(mem_ready_i));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // ring wraps to base on reaching bound, linear just counts on
  function automatic logic [15:0] nxt(logic [15:0] a);
    return (circ && a + 16'h0001 == bound) ? base : a + 16'h0001;
  endfunction
  task automatic chk_reg(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_mem(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: mem got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk_i);
    reg_addr_i <= a; reg_wdata_i <= x; reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_o;
  endtask
  task automatic put(input logic [7:0] x);
    int n;
    n = 0;
    @(posedge clk_i);
    rx_valid_i <= 1'b1; rx_data_i <= x;
    @(negedge clk_i);
    while (rx_ready_o !== 1'b1 && n < 200) begin @(negedge clk_i); n++; end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
  endtask
  task automatic exp(input logic [7:0] x);
    int n;
    n = 0;
    while (mem.got.size() == 0 && n < 300) begin @(negedge clk_i); n++; end
    chk_mem(mem.got.size() ? mem.got.pop_front() : 32'h0, {8'h12, p, x});
    p = nxt(p);
  endtask
  task automatic flag(input logic [15:0] x);
    repeat (4) @(negedge clk_i);
    rd(REG_GLOB);
    chk_reg(v, x);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("Error %0t: run took too long", $time);
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(REG_CTRL); chk_reg(v, 16'h0000);
    rd(REG_FCSR); chk_reg(v & 16'h0073, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      d = {8'h00, rnd()}; wr(ra[i], d); rd(ra[i]);
      chk_reg(v, ra[i] == 4'hE ? 16'h0000 : d);
    end
    $display("test registers done");
    base = 16'h0100; bound = 16'h0200; circ = 1'b1; p = 16'h01FE;
    wr(REG_SEG, 16'h0012); wr(REG_BASE, 16'h0001); wr(REG_BOUND, 16'h0002);
    wr(REG_PTR, p); wr(REG_BCNT, 16'h0003); wr(REG_GLOB, 16'hFFFF);
    wr(REG_CTRL, 16'h001D);
    for (int i = 0; i < 2; i++) begin d = rnd(); put(d[7:0]); exp(d[7:0]); end
    flag(16'h0000);
    for (int i = 0; i < 6; i++) begin q[i] = rnd(); put(q[i]); end
    for (int i = 0; i < 6; i++) exp(q[i]);
    flag(16'h0001);
    chk_reg({15'h0000, irq_o}, 16'h0001);
    $display("test periodic ring done");
    wr(REG_CTRL, 16'h0010); wr(REG_GLOB, 16'hFFFF); wr(REG_PTR, 16'h0300);
    p = 16'h0300; circ = 1'b0;
    @(posedge clk_i); autobaud_start_i <= 1'b1;
    @(posedge clk_i); autobaud_start_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin q[i] = rnd(); put(q[i]); end
    @(posedge clk_i); pkt_end_i <= 1'b1; pkt_abort_i <= 1'b1;
    @(posedge clk_i); pkt_end_i <= 1'b0; pkt_abort_i <= 1'b0;
    for (int i = 0; i < 3; i++) exp(q[i]);
    exp(8'h03); exp(8'h80);
    flag(16'h0001);
    $display("test chain done");
    wr(REG_CTRL, 16'h0007); wr(REG_GLOB, 16'hFFFF);
    for (int k = 0; k < 4; k++) wr(4'(REG_MATCH0 + k), 16'h00A0 + 16'(k));
    for (int k = 0; k < 4; k++) begin
      d = rnd() & 8'h7F; put(d[7:0]); exp(d[7:0]);
      flag(16'h0000);
      put(8'hA0 + 8'(k)); exp(8'hA0 + 8'(k));
      flag(16'h0001);
      wr(REG_GLOB, 16'h0001);
    end
    $display("test match done");
    wr(REG_GAP, 16'h0002); wr(REG_CTRL, 16'h0026);
    d = rnd(); put(d[7:0]); exp(d[7:0]);
    repeat (900) @(negedge clk_i);
    d = rnd(); put(d[7:0]); exp(d[7:0]);
    repeat (900) @(negedge clk_i);
    flag(16'h0000);
    repeat (1200) @(negedge clk_i);
    flag(16'h0002);
    chk_reg({15'h0000, irq_o}, 16'h0001);
    $display("test timeout done");
    tally_and_finish;
  end
endmodule
